// file: common/led_dim_params.svh
// Register offsets, field positions, reset values and counts
`ifndef LED_DIM_PARAMS_SVH
`define LED_DIM_PARAMS_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define REG_FAULT_STATUS 8'h00
`define REG_DEVICE_CONTROL 8'h01
`define REG_STRING_CURRENT_LEVEL 8'h02
`define REG_DUTY_CODE_UPPER 8'h03
`define REG_DUTY_CODE_LOWER 8'h04
`define REG_DIMMING_RATE_DIVIDER 8'h05
`define REG_LOOP_DIVIDER_HIGH 8'h06
`define REG_LOOP_DIVIDER_MID 8'h07
`define REG_LOOP_DIVIDER_LOW 8'h08

// ****************************************************
// Device control fields
// ****************************************************
`define CTL_WIN_HI 7
`define CTL_WIN_LO 6
`define CTL_HIGH_RATE 5
`define CTL_CHECK_EN 4
`define CTL_TRACK_EN 3
`define CTL_STAGGER 2
`define CTL_DUTY_SRC 1
`define CTL_DIM_SRC 0

// ****************************************************
// Reset values and constants
// ****************************************************
`define RST_DEVICE_CONTROL 8'hB5
`define RST_CURRENT_LEVEL 8'h1F
`define RST_DIVIDER_LOW 8'h08
`define RST_ZERO 8'h00
`define SLAVE_ADDR 7'h2F
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`define STEPS_SLOW 1024
`define PWM_LAST_SLOW 10'h3FF
`define PWM_LAST_FAST 10'h1FF

`endif

// file: common/led_dim_pkg.sv
// Types shared by the dimming control block
package led_dim_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_ACK_A = 4'h2,
        S_REG = 4'h3,
        S_ACK_R = 4'h4,
        S_WDATA = 4'h5,
        S_ACK_W = 4'h6,
        S_RDATA = 4'h7,
        S_RACK = 4'h8,
        S_DONE = 4'h9
    } i2c_state_t;

    typedef struct packed {
        logic boost_sync_present;
        logic pll_ready;
        logic string_short_flag;
        logic string_open_flag;
        logic video_sync_present;
        logic thermal_flag;
        logic overvoltage_flag;
    } fault_in_t;
endpackage : led_dim_pkg

// file: rtl/led_dimming_control_regs.sv
// I2C register set and PWM dimming engine of the LED string driver
//
// Contract
// RULE_01 - Bit 7 shows boost sync detected
// RULE_02 - Bit 5 flags any shorted string
// RULE_03 - Bit 4 flags any open string
// RULE_04 - Bit 3 shows video sync detected
// RULE_05 - Bit 2 flags thermal shutdown
// RULE_06 - Bit 1 flags output over-voltage
// RULE_07 - Bit 0 is OR of faults
// RULE_08 - Saved duty replaced after two outside samples
// RULE_09 - High rate: 9-bit duty, 512 steps
// RULE_10 - Low rate: 10-bit duty, 1024 steps
// RULE_11 - Open/short checked only when enabled
// RULE_12 - Track enable makes PLL follow sync
// RULE_13 - Stagger phase-shifts strings, internal source only
// RULE_14 - Duty from pin or registers, internal only
// RULE_15 - Source 0 passes pin, 1 internal
// RULE_16 - Current level code drives current DAC
// RULE_17 - Ten-bit duty from upper and lower
// RULE_18 - Eighteen-bit loop divider goes to PLL
// RULE_19 - No address auto increment
// RULE_20 - I2C slave at seven-bit address 0x2F
// RULE_21 - Status register writes are ignored
`include "led_dim_params.svh"

module led_dimming_control_regs #(
    parameter int STRINGS = 4
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic i_duty_input_pin,
    input wire led_dim_pkg::fault_in_t i_faults,
    output logic [STRINGS-1:0] o_string_pwm,
    output logic [7:0] o_current_level_code,
    output logic [17:0] o_loop_divider,
    output logic o_pll_enable,
    output logic o_sync_track_enable
);
    // ****************************************************
    // Input synchronisers
    // ****************************************************
    localparam int NIN = 10;
    logic [NIN-1:0] in_vec, s1_reg, s2_reg, s3_reg, filt_reg;
    logic scl_d_reg, sda_d_reg;
    assign in_vec = {i_faults, i_duty_input_pin, i_sda, i_scl};

    // A bit only moves once stages two and three agree
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            // Stages start at the idle pin levels so no false edge follows
            s1_reg <= 10'h003;
            s2_reg <= 10'h003;
            s3_reg <= 10'h003;
            filt_reg <= 10'h003;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            s1_reg <= in_vec;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
            scl_d_reg <= filt_reg[0];
            sda_d_reg <= filt_reg[1];
        end
    end

    led_dim_pkg::fault_in_t flt;
    logic scl_f, sda_f, pin_f, scl_rise, scl_fall, start, stop;
    assign scl_f = filt_reg[0];
    assign sda_f = filt_reg[1];
    assign pin_f = filt_reg[2];
    assign flt = led_dim_pkg::fault_in_t'(filt_reg[NIN-1:3]);
    assign scl_rise = scl_f & ~scl_d_reg;
    assign scl_fall = ~scl_f & scl_d_reg;
    assign start = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
    assign stop = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0] ctrl_reg, level_reg, duty_lo_reg, freq_reg;
    logic [7:0] div_mid_reg, div_lo_reg;
    logic [1:0] duty_hi_reg, div_hi_reg;
    logic [7:0] stat, rd_data, ptr_reg, sh_reg, tx_reg;
    logic short_g, open_g, wr_stb;
    led_dim_pkg::i2c_state_t state_reg;
    logic [3:0] cnt_reg;
    logic rw_reg;

    assign short_g = ctrl_reg[`CTL_CHECK_EN] & flt.string_short_flag; // [RULE_11]
    assign open_g = ctrl_reg[`CTL_CHECK_EN] & flt.string_open_flag; // [RULE_11]
    assign stat = {flt.boost_sync_present, // [RULE_01]
                   flt.pll_ready,
                   short_g, // [RULE_02]
                   open_g, // [RULE_03]
                   flt.video_sync_present, // [RULE_04]
                   flt.thermal_flag, // [RULE_05]
                   flt.overvoltage_flag, // [RULE_06]
                   short_g | open_g | flt.thermal_flag
                   | flt.overvoltage_flag}; // [RULE_07]

    // Unmapped offsets read as zero
    always_comb begin
        if (ptr_reg == `REG_FAULT_STATUS) begin
            rd_data = stat;
        end else if (ptr_reg == `REG_DEVICE_CONTROL) begin
            rd_data = ctrl_reg;
        end else if (ptr_reg == `REG_STRING_CURRENT_LEVEL) begin
            rd_data = level_reg;
        end else if (ptr_reg == `REG_DUTY_CODE_UPPER) begin
            rd_data = {6'h00, duty_hi_reg};
        end else if (ptr_reg == `REG_DUTY_CODE_LOWER) begin
            rd_data = duty_lo_reg;
        end else if (ptr_reg == `REG_DIMMING_RATE_DIVIDER) begin
            rd_data = freq_reg;
        end else if (ptr_reg == `REG_LOOP_DIVIDER_HIGH) begin
            rd_data = {6'h00, div_hi_reg};
        end else if (ptr_reg == `REG_LOOP_DIVIDER_MID) begin
            rd_data = div_mid_reg;
        end else if (ptr_reg == `REG_LOOP_DIVIDER_LOW) begin
            rd_data = div_lo_reg;
        end else begin
            rd_data = 8'h00;
        end
    end

    assign wr_stb = scl_fall && state_reg == led_dim_pkg::S_WDATA
                    && cnt_reg == `BYTE_BITS;

    // Status offset has no write branch: writes there fall away
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_reg <= `RST_DEVICE_CONTROL;
            level_reg <= `RST_CURRENT_LEVEL;
            duty_hi_reg <= 2'h0;
            duty_lo_reg <= `RST_ZERO;
            freq_reg <= `RST_ZERO;
            div_hi_reg <= 2'h0;
            div_mid_reg <= `RST_ZERO;
            div_lo_reg <= `RST_DIVIDER_LOW;
        end else if (wr_stb) begin // [RULE_21]
            if (ptr_reg == `REG_DEVICE_CONTROL) begin
                ctrl_reg <= sh_reg;
            end else if (ptr_reg == `REG_STRING_CURRENT_LEVEL) begin
                level_reg <= sh_reg;
            end else if (ptr_reg == `REG_DUTY_CODE_UPPER) begin
                duty_hi_reg <= sh_reg[1:0];
            end else if (ptr_reg == `REG_DUTY_CODE_LOWER) begin
                duty_lo_reg <= sh_reg;
            end else if (ptr_reg == `REG_DIMMING_RATE_DIVIDER) begin
                freq_reg <= sh_reg;
            end else if (ptr_reg == `REG_LOOP_DIVIDER_HIGH) begin
                div_hi_reg <= sh_reg[1:0];
            end else if (ptr_reg == `REG_LOOP_DIVIDER_MID) begin
                div_mid_reg <= sh_reg;
            end else if (ptr_reg == `REG_LOOP_DIVIDER_LOW) begin
                div_lo_reg <= sh_reg;
            end
        end
    end

    // ****************************************************
    // I2C slave
    // ****************************************************
    // One register per transfer; the pointer never advances
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_reg <= led_dim_pkg::S_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (start) begin
            state_reg <= led_dim_pkg::S_ADDR;
            cnt_reg <= 4'h0;
            o_sda_oe_n <= 1'b1;
        end else if (stop) begin
            state_reg <= led_dim_pkg::S_IDLE;
            o_sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            if (state_reg == led_dim_pkg::S_ADDR
                || state_reg == led_dim_pkg::S_REG
                || state_reg == led_dim_pkg::S_WDATA) begin
                sh_reg <= {sh_reg[6:0], sda_f};
                cnt_reg <= cnt_reg + 4'h1;
            end else if (state_reg == led_dim_pkg::S_RACK) begin
                state_reg <= led_dim_pkg::S_DONE;
            end
        end else if (scl_fall) begin
            case (state_reg)
                led_dim_pkg::S_ADDR: begin
                    if (cnt_reg == `BYTE_BITS) begin
                        if (sh_reg[7:1] == `SLAVE_ADDR) begin // [RULE_20]
                            rw_reg <= sh_reg[0];
                            o_sda_oe_n <= 1'b0;
                            state_reg <= led_dim_pkg::S_ACK_A;
                        end else begin
                            state_reg <= led_dim_pkg::S_DONE;
                        end
                    end
                end
                led_dim_pkg::S_ACK_A: begin
                    cnt_reg <= 4'h0;
                    if (rw_reg) begin
                        o_sda_oe_n <= rd_data[7];
                        tx_reg <= {rd_data[6:0], 1'b0};
                        state_reg <= led_dim_pkg::S_RDATA;
                    end else begin
                        o_sda_oe_n <= 1'b1;
                        state_reg <= led_dim_pkg::S_REG;
                    end
                end
                led_dim_pkg::S_REG: begin
                    if (cnt_reg == `BYTE_BITS) begin
                        ptr_reg <= sh_reg; // [RULE_19]
                        o_sda_oe_n <= 1'b0;
                        state_reg <= led_dim_pkg::S_ACK_R;
                    end
                end
                led_dim_pkg::S_ACK_R: begin
                    cnt_reg <= 4'h0;
                    o_sda_oe_n <= 1'b1;
                    state_reg <= led_dim_pkg::S_WDATA;
                end
                led_dim_pkg::S_WDATA: begin
                    if (cnt_reg == `BYTE_BITS) begin
                        o_sda_oe_n <= 1'b0;
                        state_reg <= led_dim_pkg::S_ACK_W;
                    end
                end
                led_dim_pkg::S_ACK_W: begin
                    o_sda_oe_n <= 1'b1;
                    state_reg <= led_dim_pkg::S_DONE; // [RULE_19]
                end
                led_dim_pkg::S_RDATA: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == `LAST_BIT) begin
                        o_sda_oe_n <= 1'b1;
                        state_reg <= led_dim_pkg::S_RACK;
                    end else begin
                        o_sda_oe_n <= tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************
    // PWM engine
    // ****************************************************
    logic [7:0] pre_reg;
    logic [9:0] pos_reg, hi_reg, saved_reg, last, meas_diff, duty_sel;
    logic [9:0] duty_eff;
    logic miss_reg, tick, wrap, fast, outside, upd;
    logic [STRINGS-1:0] pwm_next;

    assign fast = ctrl_reg[`CTL_HIGH_RATE];
    assign last = fast ? `PWM_LAST_FAST : `PWM_LAST_SLOW; // [RULE_09] [RULE_10]
    assign tick = pre_reg == freq_reg;
    assign wrap = tick && pos_reg >= last;
    assign meas_diff = hi_reg > saved_reg ? hi_reg - saved_reg
                                          : saved_reg - hi_reg;
    assign outside = meas_diff > {8'h00, ctrl_reg[`CTL_WIN_HI:`CTL_WIN_LO]};
    assign upd = wrap && outside && miss_reg; // [RULE_08]
    assign duty_sel = ctrl_reg[`CTL_DUTY_SRC] // [RULE_14]
                      ? {duty_hi_reg, duty_lo_reg} : saved_reg; // [RULE_17]
    assign duty_eff = fast ? {1'b0, duty_sel[8:0]} : duty_sel; // [RULE_09]

    // Period is (divider + 1) clocks per step times 512 or 1024 steps
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pre_reg <= 8'h00;
            pos_reg <= 10'h000;
            hi_reg <= 10'h000;
            saved_reg <= 10'h000;
            miss_reg <= 1'b0;
        end else begin
            pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
            if (wrap) begin
                pos_reg <= 10'h000;
                hi_reg <= 10'h000;
                saved_reg <= upd ? hi_reg : saved_reg; // [RULE_08]
                miss_reg <= outside && !miss_reg;
            end else if (tick) begin
                pos_reg <= pos_reg + 10'h001;
                hi_reg <= hi_reg + {9'h000, pin_f};
            end
        end
    end

    // Full-scale code holds the string on for the whole period
    genvar k;
    generate
        for (k = 0; k < STRINGS; k++) begin : g_str
            localparam logic [10:0] OFS_S = 11'(k * `STEPS_SLOW / STRINGS);
            logic [10:0] sum, ofs;
            logic [9:0] ph;
            assign ofs = !ctrl_reg[`CTL_STAGGER] ? 11'h000 // [RULE_13]
                         : fast ? {1'b0, OFS_S[10:1]} : OFS_S;
            assign sum = {1'b0, pos_reg} + ofs;
            assign ph = sum > {1'b0, last} ? 10'(sum - {1'b0, last} - 11'h001)
                                           : sum[9:0];
            assign pwm_next[k] = ctrl_reg[`CTL_DIM_SRC] // [RULE_15]
                                 ? (ph < duty_eff || duty_eff == last)
                                 : pin_f;
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_string_pwm <= '0;
            o_current_level_code <= `RST_CURRENT_LEVEL;
            o_loop_divider <= 18'h00008;
            o_pll_enable <= 1'b0;
            o_sync_track_enable <= 1'b0;
            o_sda <= 1'b0;
        end else begin
            o_string_pwm <= pwm_next;
            o_current_level_code <= level_reg; // [RULE_16]
            o_loop_divider <= {div_hi_reg, div_mid_reg, div_lo_reg}; // [RULE_18]
            o_pll_enable <= ctrl_reg[`CTL_DIM_SRC]; // [RULE_15]
            o_sync_track_enable <= ctrl_reg[`CTL_TRACK_EN]; // [RULE_12]
            o_sda <= 1'b0;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    property p_any_fault;
        stat[0] == (stat[5] | stat[4] | stat[2] | stat[1]);
    endproperty
    a_any_fault: assert property (p_any_fault) // [RULE_07]
        else $error("any-fault bit wrong");
    property p_check_off;
        !ctrl_reg[`CTL_CHECK_EN] |-> !stat[5] && !stat[4];
    endproperty
    a_check_off: assert property (p_check_off) // [RULE_11]
        else $error("string fault shown while checks off");
    property p_boost;
        stat[7] == flt.boost_sync_present && stat[3] == flt.video_sync_present;
    endproperty
    a_boost: assert property (p_boost) // [RULE_01]
        else $error("sync presence bits wrong");
    property p_direct;
        !ctrl_reg[`CTL_DIM_SRC] |=> o_string_pwm == {STRINGS{$past(pin_f)}};
    endproperty
    a_direct: assert property (p_direct) // [RULE_15]
        else $error("direct mode does not follow pin");
    property p_saved;
        saved_reg != $past(saved_reg) |-> $past(miss_reg) && $past(wrap);
    endproperty
    a_saved: assert property (p_saved) // [RULE_08]
        else $error("saved duty changed without two misses");
    property p_fast_span;
        fast && tick |=> pos_reg <= `PWM_LAST_FAST;
    endproperty
    a_fast_span: assert property (p_fast_span) // [RULE_09]
        else $error("step count beyond 512 in high rate");
    property p_ack;
        scl_fall && state_reg == led_dim_pkg::S_ADDR && cnt_reg == `BYTE_BITS
        && sh_reg[7:1] == `SLAVE_ADDR && !start && !stop |=> !o_sda_oe_n;
    endproperty
    a_ack: assert property (p_ack) // [RULE_20]
        else $error("no acknowledge of own address");
    property p_level;
        ##1 o_current_level_code == $past(level_reg);
    endproperty
    a_level: assert property (p_level) // [RULE_16]
        else $error("current level output stale");
    property p_status_wr;
        wr_stb && ptr_reg == `REG_FAULT_STATUS |=> $stable(ctrl_reg);
    endproperty
    a_status_wr: assert property (p_status_wr) // [RULE_21]
        else $error("status write disturbed control");
endmodule : led_dimming_control_regs

// file: sim/i2c_host_model.sv
// Host model: bit-level I2C master driving the register interface
module i2c_host_model (
    input wire logic i_mclk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************
    // Bus timing
    // ****************************************************
    // Phases of 11 mclk keep SCL high and low above 1 us
    localparam int Q = 11;

    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : wait_clk

    // Data moves 3 mclk after SCL falls so the filtered edges never coincide
    task automatic bit_io(input logic b, output logic r);
        wait_clk(3);
        o_sda_low = ~b;
        wait_clk(Q);
        o_scl = 1'b1;
        wait_clk(Q);
        r = i_sda;
        o_scl = 1'b0;
    endtask : bit_io

    // Sending 0xFF releases SDA, so one task serves writes and reads
    task automatic byte_io(input logic [7:0] b, output logic [7:0] r,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(1'b1, ack);
    endtask : byte_io

    task automatic start;
        wait_clk(3);
        o_sda_low = 1'b0;
        wait_clk(Q);
        o_scl = 1'b1;
        wait_clk(Q);
        o_sda_low = 1'b1;
        wait_clk(Q);
        o_scl = 1'b0;
    endtask : start

    task automatic stop;
        wait_clk(3);
        o_sda_low = 1'b1;
        wait_clk(Q);
        o_scl = 1'b1;
        wait_clk(Q);
        o_sda_low = 1'b0;
        wait_clk(Q);
    endtask : stop

    // ****************************************************
    // Register transfers
    // ****************************************************
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                             output logic [2:0] acks);
        logic [7:0] r;
        start();
        byte_io(8'h5E, r, acks[2]);
        byte_io(a, r, acks[1]);
        byte_io(d, r, acks[0]);
        stop();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic [2:0] acks);
        logic [7:0] r;
        logic nack;
        start();
        byte_io(8'h5E, r, acks[2]);
        byte_io(a, r, acks[1]);
        start();
        byte_io(8'h5F, r, acks[0]);
        byte_io(8'hFF, d, nack);
        stop();
    endtask : read_reg
endmodule : i2c_host_model

// file: sim/led_dimming_control_regs_bench.sv
// Self-checking bench for the LED dimming control register block
module led_dimming_control_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_duty_input_pin = 1'b0;
    led_dim_pkg::fault_in_t faults = '0;
    logic scl, sda_low, sda_wire, o_sda, o_sda_oe_n;
    logic pll_en, track_en;
    logic [3:0] pwm;
    logic [7:0] level, r;
    logic [17:0] dvd;
    logic ack;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] rst_val [0:9] = '{8'h00, 8'hB5, 8'h1F, 8'h00, 8'h00,
                                  8'h00, 8'h00, 8'h00, 8'h08, 8'h00};

    // SDA has a pull-up; either party may pull it low
    assign sda_wire = ~(sda_low | (~o_sda_oe_n & ~o_sda));

    led_dimming_control_regs led_dimming_control_regs_i (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(scl),
        .i_sda(sda_wire), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
        .i_duty_input_pin(i_duty_input_pin), .i_faults(faults),
        .o_string_pwm(pwm), .o_current_level_code(level),
        .o_loop_divider(dvd), .o_pll_enable(pll_en),
        .o_sync_track_enable(track_en)
    );

    i2c_host_model i2c_host_model_i (
        .i_mclk(i_mclk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low)
    );

    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    // ****************************************************
    // Checking and closing
    // ****************************************************
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [17:0] seen,
                         input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Runs near 72k cycles; the ceiling leaves some margin
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 100000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [2:0] acks;
        i2c_host_model_i.write_reg(a, d, acks);
        check("write acks", 18'(acks), 18'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [2:0] acks;
        logic [7:0] d;
        i2c_host_model_i.read_reg(a, d, acks);
        check("read acks", 18'(acks), 18'h0);
        check("read data", 18'(d), 18'(exp));
    endtask : rd

    // Counts mclk cycles of string 0 on and of strings 0 and 1 differing
    task automatic pwm_case(input logic [7:0] ctl, input logic [7:0] dv,
                            input logic [9:0] dt, input int on, input int df);
        int per, n_on, n_df;
        per = (ctl[5] ? 512 : 1024) * (int'(dv) + 1);
        wr(8'h05, dv);
        wr(8'h03, {6'h00, dt[9:8]});
        wr(8'h04, dt[7:0]);
        wr(8'h01, ctl);
        repeat (2 * per) @(negedge i_mclk);
        n_on = 0;
        n_df = 0;
        repeat (per) begin
            @(negedge i_mclk);
            n_on += int'(pwm[0] === 1'b1);
            n_df += int'((pwm[0] ^ pwm[1]) === 1'b1);
        end
        check("on count", 18'(n_on), 18'(on));
        check("difference count", 18'(n_df), 18'(df));
    endtask : pwm_case

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk) i_sys_rst = 1'b0;
        repeat (6) @(negedge i_mclk);
        for (int a = 0; a < 10; a++) begin
            rd(8'(a), rst_val[a]);
        end
        check("level", 18'(level), 18'h1F);
        check("divider", dvd, 18'h00008);
        check("pll enable", 18'(pll_en), 18'h1);
        check("track", 18'(track_en), 18'h0);
        i2c_host_model_i.start();
        i2c_host_model_i.byte_io(8'h60, r, ack);
        i2c_host_model_i.stop();
        check("foreign address ack", 18'(ack), 18'h1);
        wr(8'h02, 8'hA5);
        check("level", 18'(level), 18'hA5);
        wr(8'h06, 8'h03);
        wr(8'h07, 8'h12);
        wr(8'h08, 8'h34);
        check("divider", dvd, 18'h31234);
        rd(8'h07, 8'h12);
        // Pointer must still be 0x07 for a read without a new address
        i2c_host_model_i.start();
        i2c_host_model_i.byte_io(8'h5F, r, ack);
        i2c_host_model_i.byte_io(8'hFF, r, ack);
        i2c_host_model_i.stop();
        check("pointer kept", 18'(r), 18'h12);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        for (int i = 0; i < 7; i++) begin
            faults = led_dim_pkg::fault_in_t'(7'h01 << i);
            rd(8'h00, {7'h01 << i, |((7'h01 << i) & 7'h1B)});
        end
        wr(8'h01, 8'hA5);
        faults = led_dim_pkg::fault_in_t'(7'h18);
        rd(8'h00, 8'h00);
        faults = '0;
        wr(8'h01, 8'h08);
        check("track", 18'(track_en), 18'h1);
        check("pll enable", 18'(pll_en), 18'h0);
        i_duty_input_pin = 1'b1;
        repeat (8) @(negedge i_mclk);
        check("direct high", 18'(pwm), 18'hF);
        i_duty_input_pin = 1'b0;
        repeat (8) @(negedge i_mclk);
        check("direct low", 18'(pwm), 18'h0);
        pwm_case(8'h23, 8'h00, 10'h280, 128, 0);
        pwm_case(8'h03, 8'h00, 10'h280, 640, 0);
        pwm_case(8'h27, 8'h01, 10'h080, 256, 512);
        pwm_case(8'h23, 8'h00, 10'h1FF, 512, 0);
        pwm_case(8'h03, 8'h00, 10'h3FF, 1024, 0);
        pwm_case(8'h03, 8'h00, 10'h000, 0, 0);
        // Duty taken from the pin: a steady high pin saves full scale
        i_duty_input_pin = 1'b1;
        pwm_case(8'hC1, 8'h00, 10'h000, 1024, 0);
        i_duty_input_pin = 1'b0;
        pwm_case(8'h01, 8'h00, 10'h3FF, 0, 0);
        test_done();
    end
endmodule : led_dimming_control_regs_bench
